// ===== hw/ssp_map.svh
// Constants for the SPI register port: frame lengths, field positions, sizes
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// Frame lengths in serial clocks
`define SSP_LEN_ONE 6'h10
`define SSP_LEN_TWO 6'h18
`define SSP_LEN_THREE 6'h20
`define SSP_LEN_TRUNC 6'h1f
`define SSP_CNT_MAX 6'h3f
`define SSP_CNT_W 6

// Command byte layout: seven address bits, then the direction bit
`define SSP_ADDR_W 7
`define SSP_ADDR_DONE 6'h07
`define SSP_RW_BIT 0
`define SSP_RW_WRITE 1'b1
`define SSP_STATUS_MSB 7

// Register file
`define SSP_NREG 128
`define SSP_REG_RESET 8'h00

`endif

// ===== hw/ssp_pkg.sv
// Types shared by the SPI register port
package ssp_pkg;

  typedef logic [7:0] ssp_byte_t;

  typedef enum logic {
    SSP_PH_IDLE,
    SSP_PH_FRAME
  } ssp_phase_t;

endpackage : ssp_pkg

// ===== hw/ssp_link_if.sv
// Signals between the serial-clock shifter and the system-clock core
`timescale 1ns/1ps
interface ssp_link_if;
  logic [5:0] bit_cnt;
  logic [31:0] shift;
  logic req_tgl;
  logic [6:0] req_addr;
  logic [7:0] status;
  logic [23:0] rdata;

  modport shifter (
    output bit_cnt,
    output shift,
    output req_tgl,
    output req_addr,
    input status,
    input rdata
  );

  modport core (
    input bit_cnt,
    input shift,
    input req_tgl,
    input req_addr,
    output status,
    output rdata
  );
endinterface : ssp_link_if

// ===== hw/ssp_shifter.sv
// Serial-clock side of the SPI register port: bit counter and shifters
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_shifter
  import ssp_pkg::*;
(
  // Link
  input wire logic sclk_in,
  input wire logic chip_select_active_low_in,
  input wire logic sdi_in,
  output logic sdo_bit_out,
  // Reset
  input wire logic rst_b_in,
  // Core side
  ssp_link_if.shifter lnk
);

  logic frame_clr;
  logic fresh_r;
  logic started_r;
  logic sdo_r;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic req_tgl_r;
  logic [6:0] req_addr_r;
  logic [31:0] stream;
  logic out_bit;

  // A deselected link clears the frame state without any clock edge
  assign frame_clr = chip_select_active_low_in | ~rst_b_in;

  always_ff @(posedge sclk_in or posedge frame_clr)
  begin
    if (frame_clr)
      fresh_r <= 1'b1;
    else
      fresh_r <= 1'b0;
  end

  always_comb
  begin
    cnt_nxt = fresh_r ? 6'h01 :
      ((cnt_r == `SSP_CNT_MAX) ? cnt_r : cnt_r + 6'h01);
    shift_nxt = fresh_r ? {31'h0, sdi_in} : {shift_r[30:0], sdi_in};
  end

  // Rising edge capture
  // Count and shift are not cleared by deselect so the core can read them
  always_ff @(posedge sclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_r <= 6'h00;
      shift_r <= 32'h0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
    end
  end

  always_ff @(posedge sclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      req_tgl_r <= 1'b0;
      req_addr_r <= 7'h00;
    end
    else if (cnt_nxt == `SSP_ADDR_DONE)
    begin
      req_tgl_r <= ~req_tgl_r;
      req_addr_r <= shift_nxt[6:0];
    end
  end

  assign stream = {lnk.status, lnk.rdata};
  assign out_bit = cnt_r[5] ? 1'b0 : stream[5'(5'h1f - cnt_r[4:0])];

  always_ff @(negedge sclk_in or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      started_r <= 1'b0;
      sdo_r <= 1'b0;
    end
    else
    begin
      started_r <= 1'b1;
      sdo_r <= out_bit;
    end
  end

  assign sdo_bit_out = started_r ? sdo_r : lnk.status[`SSP_STATUS_MSB];

  assign lnk.bit_cnt = cnt_r;
  assign lnk.shift = shift_r;
  assign lnk.req_tgl = req_tgl_r;
  assign lnk.req_addr = req_addr_r;

  a_addr_request: assert property (
    @(posedge sclk_in) disable iff (frame_clr)
    $changed(req_tgl_r) |-> (cnt_r == `SSP_ADDR_DONE) &&
      (req_addr_r == shift_r[6:0]))
    else $error("address request not at seventh bit");

  a_count_steps: assert property (
    @(posedge sclk_in) disable iff (frame_clr)
    !fresh_r && cnt_r < 6'h3e |=> cnt_r == $past(cnt_r) + 6'h01)
    else $error("bit counter did not advance");

endmodule : ssp_shifter

// ===== hw/ssp_spi_port.sv
// SPI register port of the system basis chip: register file and frame commit
// Function
// - A frame is 16, 24 or 32 clocks: command then 1-3 data bytes.
// - First byte out is global status, then the response bytes.
// - Write returns each register's old contents before storing new.
// - Read returns current contents and changes no register.
// - Input data is captured on rising serial clock edges.
// - Output data changes on falling serial clock edges.
// - In sleep the port ignores frames; host must wake device first.
// - Write clock count sets bytes stored, to incrementing addresses.
// - Input bits shift in on every rising clock edge; chip select high restarts the count.
// - Write data commits only after a 16, 24, 31 or 32 clock count and chip select rise.
// - A 31-clock burst write stores two bytes and drops the third.
// - A frame with a bad clock count sets the framing error flag.
// - On chip select fall, output shows global status bit 7 at once.
// - Output is released to high impedance while deselected.
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_spi_port
  import ssp_pkg::*;
#(
  parameter int NREG = `SSP_NREG
)
(
  // System clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Serial link
  input wire logic sclk_in,
  input wire logic chip_select_active_low_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // Device state
  input wire logic sleep_mode_in,
  input wire logic [7:0] global_status_in,
  // Register file view
  input wire logic [6:0] core_addr_in,
  output logic [7:0] core_rdata_out,
  // Commit and error reporting
  output logic wr_pulse_out,
  output logic [1:0] wr_count_out,
  input wire logic err_clear_in,
  output logic serial_framing_error_flag_out
);

  ssp_link_if lnk ();

  ssp_phase_t phase_r;
  logic cs_meta_r;
  logic cs_sync_r;
  logic cs_prev_r;
  logic cs_rise;
  logic cs_fall;
  logic req_meta_r;
  logic req_sync_r;
  logic req_prev_r;
  logic fetch;
  logic sleep_r;
  ssp_byte_t status_r;
  logic [23:0] rdata_r;
  ssp_byte_t regs_r [NREG];
  ssp_byte_t core_rdata_r;
  logic err_r;
  logic wr_pulse_r;
  logic [1:0] wr_count_r;
  logic [31:0] aligned;
  ssp_byte_t cmd;
  logic [6:0] base;
  logic is_write;
  logic len_ok;
  logic [1:0] n_commit;
  logic end_frame;

  // Number of whole data bytes a frame of this length may store
  function automatic logic [1:0] commit_bytes(input logic [5:0] cnt);
    logic [1:0] n;
    n = 2'h0;
    unique case (cnt)
      `SSP_LEN_ONE: n = 2'h1;
      `SSP_LEN_TWO: n = 2'h2;
      `SSP_LEN_TRUNC: n = 2'h2;
      `SSP_LEN_THREE: n = 2'h3;
      default: n = 2'h0;
    endcase
    return n;
  endfunction : commit_bytes

  function automatic logic length_legal(input logic [5:0] cnt);
    return (cnt == `SSP_LEN_ONE) || (cnt == `SSP_LEN_TWO) ||
      (cnt == `SSP_LEN_THREE);
  endfunction : length_legal

  ssp_shifter u_shifter (
    .sclk_in(sclk_in),
    .chip_select_active_low_in(chip_select_active_low_in),
    .sdi_in(sdi_in),
    .sdo_bit_out(sdo_out),
    .rst_b_in(rst_b_in),
    .lnk(lnk)
  );

  // Chip select and request toggle cross into the system clock
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
      req_prev_r <= 1'b0;
    end
    else
    begin
      cs_meta_r <= chip_select_active_low_in;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
      req_meta_r <= lnk.req_tgl;
      req_sync_r <= req_meta_r;
      req_prev_r <= req_sync_r;
    end
  end

  assign cs_rise = cs_sync_r & ~cs_prev_r;
  assign cs_fall = ~cs_sync_r & cs_prev_r;
  assign fetch = req_sync_r ^ req_prev_r;

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sleep_r <= 1'b1;
    else
      sleep_r <= sleep_mode_in;
  end

  // Frames begun in sleep are ignored
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      phase_r <= SSP_PH_IDLE;
    else
    begin
      unique case (phase_r)
        SSP_PH_IDLE:
          if (cs_fall && !sleep_r)
            phase_r <= SSP_PH_FRAME;
        SSP_PH_FRAME:
          if (cs_rise)
            phase_r <= SSP_PH_IDLE;
      endcase
    end
  end

  assign end_frame = (phase_r == SSP_PH_FRAME) && cs_rise && !sleep_r;

  // Driver only while selected and awake
  // Enable follows the pin directly so the release needs no clock
  assign sdo_oe_out = ~chip_select_active_low_in & ~sleep_r;

  // Status is frozen for the frame so the shifted byte is consistent
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      status_r <= 8'h00;
    else if (phase_r == SSP_PH_IDLE && cs_sync_r)
      status_r <= global_status_in;
  end

  // Old contents fetched before any commit
  // Fetch is read only
  // Three bytes are fetched at once; the serial side needs the first
  // within one and a half serial clocks, far longer than the crossing takes
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rdata_r <= 24'h0;
    else if (fetch)
      rdata_r <= {regs_r[lnk.req_addr], regs_r[7'(lnk.req_addr + 7'h1)],
        regs_r[7'(lnk.req_addr + 7'h2)]};
  end

  assign lnk.status = status_r;
  assign lnk.rdata = rdata_r;

  // Command byte at the frame head
  // Count and shift are quiet after deselect, so they are read raw here
  always_comb
  begin
    aligned = lnk.shift << (6'h20 - lnk.bit_cnt);
    cmd = aligned[31:24];
    base = cmd[7:1];
    is_write = (cmd[`SSP_RW_BIT] == `SSP_RW_WRITE);
    len_ok = length_legal(lnk.bit_cnt);
    n_commit = commit_bytes(lnk.bit_cnt);
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      for (int i = 0; i < NREG; i++)
        regs_r[i] <= `SSP_REG_RESET;
    end
    else if (end_frame && is_write)
    begin
      for (int i = 0; i < 3; i++)
        if (2'(i) < n_commit)
          regs_r[7'(base + 7'(i))] <= aligned[23 - 8 * i -: 8];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_pulse_r <= 1'b0;
      wr_count_r <= 2'h0;
    end
    else
    begin
      wr_pulse_r <= end_frame && is_write && (n_commit != 2'h0);
      wr_count_r <= (end_frame && is_write) ? n_commit : 2'h0;
    end
  end

  // Bad length sets the flag
  // A new error wins over a clear in the same cycle
  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      err_r <= 1'b0;
    else if (end_frame && !len_ok)
      err_r <= 1'b1;
    else if (err_clear_in)
      err_r <= 1'b0;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      core_rdata_r <= 8'h00;
    else
      core_rdata_r <= regs_r[core_addr_in];
  end

  assign core_rdata_out = core_rdata_r;
  assign wr_pulse_out = wr_pulse_r;
  assign wr_count_out = wr_count_r;
  assign serial_framing_error_flag_out = err_r;

  a_commit_on_rise: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    wr_pulse_r |-> $past(cs_rise) && $past(phase_r == SSP_PH_FRAME))
    else $error("commit without a completed frame");

  a_read_no_write: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    end_frame && !is_write |=> !wr_pulse_r && wr_count_r == 2'h0)
    else $error("read frame stored data");

  a_trunc_two: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    end_frame && is_write && lnk.bit_cnt == `SSP_LEN_TRUNC
      |=> wr_pulse_r && wr_count_r == 2'h2 && err_r)
    else $error("31-clock write did not store two bytes");

  a_count_len: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    end_frame && is_write && lnk.bit_cnt == `SSP_LEN_THREE
      |=> wr_count_r == 2'h3 ##1 wr_count_r == 2'h0)
    else $error("32-clock write did not store three bytes");

  a_err_bad_len: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    end_frame && !len_ok |=> err_r)
    else $error("framing error not flagged");

  a_err_clear: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    err_clear_in && !(end_frame && !len_ok) |=> !err_r)
    else $error("framing error not cleared");

  // Byte count only with a store
  a_count_idle: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    !wr_pulse_r |-> wr_count_r == 2'h0)
    else $error("byte count shown without a store");

  a_sleep_ignore: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    sleep_r |=> !wr_pulse_r && !$rose(err_r))
    else $error("frame acted on during sleep");

  // First fetched byte is the addressed register
  a_fetch_old: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    fetch && !end_frame |=> rdata_r[23:16] == $past(regs_r[lnk.req_addr]))
    else $error("fetched byte not register contents");

  // Released while deselected
  // Also shows the serial side fell back to the early status bit
  a_oe_release: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    chip_select_active_low_in |-> !sdo_oe_out &&
      (sdo_out == status_r[`SSP_STATUS_MSB]))
    else $error("output driven while deselected");

  a_status_frozen: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    phase_r == SSP_PH_FRAME |=> $stable(status_r))
    else $error("status byte changed inside a frame");

  c_write_one: cover property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    wr_pulse_r && wr_count_r == 2'h1);

  c_write_burst: cover property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    wr_pulse_r && wr_count_r == 2'h3);

  c_read_frame: cover property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    end_frame && !is_write && len_ok);

  c_frame_error: cover property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $rose(err_r));

  c_sleep_frame: cover property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    cs_fall && sleep_r);

endmodule : ssp_spi_port

// ===== tb/ssp_host_model.sv
// Host controller model that frames transfers on the serial link
`timescale 1ns/1ps
module ssp_host_model
(
  // Link to the port
  output logic sclk_out,
  output logic chip_select_active_low_out,
  output logic sdi_out,
  // Returned data line
  input wire logic sdo_wire_in,
  input wire logic sdo_oe_in
);
  localparam int HALF = 80;
  logic [31:0] rx;
  logic first_bit;
  logic oe_any;

  // Serial clock stands still between frames
  initial
  begin
    sclk_out = 1'b0;
    chip_select_active_low_out = 1'b1;
    sdi_out = 1'b0;
  end

  task automatic xfer(input int nbits, input logic [31:0] tx);
    rx = '0;
    oe_any = 1'b0;
    #7;
    chip_select_active_low_out = 1'b0;
    #2;
    first_bit = sdo_wire_in;
    #(HALF - 2);
    for (int i = 0; i < nbits; i++)
    begin
      sdi_out = (i < 32) ? tx[31 - i] : 1'b0;
      #(HALF);
      sclk_out = 1'b1;
      rx = {rx[30:0], sdo_wire_in};
      oe_any = oe_any | sdo_oe_in;
      #(HALF);
      sclk_out = 1'b0;
    end
    #(HALF);
    chip_select_active_low_out = 1'b1;
    // Inverse after release, so a stale bit is never mistaken for data
    sdi_out = ~sdi_out;
  endtask : xfer
endmodule : ssp_host_model

// ===== tb/tb.sv
// Self-checking bench for the SPI register port
`timescale 1ns/1ps
module tb;
  import ssp_pkg::*;
  logic mclk_in, rst_b_in, sleep_mode_in, err_clear_in;
  logic [7:0] global_status_in;
  logic [6:0] core_addr_in;
  logic sclk, chip_select_active_low, sdi, sdo, sdo_oe, sdo_wire;
  logic wr_pulse, flag;
  logic [7:0] core_rdata;
  logic [1:0] wr_count;
  int failures;
  int n_checks;
  int rnd;
  int bad [6] = '{31, 20, 33, 15, 17, 8};
  ssp_byte_t mem [128];

  // No pull on the data line: a released line reads as the inverted bit
  assign sdo_wire = sdo_oe ? sdo : ~sdo;

  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  ssp_spi_port #(.NREG(128)) ssp_spi_port_inst (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .sclk_in(sclk),
    .chip_select_active_low_in(chip_select_active_low),
    .sdi_in(sdi),
    .sdo_out(sdo),
    .sdo_oe_out(sdo_oe),
    .sleep_mode_in(sleep_mode_in),
    .global_status_in(global_status_in),
    .core_addr_in(core_addr_in),
    .core_rdata_out(core_rdata),
    .wr_pulse_out(wr_pulse),
    .wr_count_out(wr_count),
    .err_clear_in(err_clear_in),
    .serial_framing_error_flag_out(flag)
  );

  ssp_host_model ssp_host_model_inst (
    .sclk_out(sclk),
    .chip_select_active_low_out(chip_select_active_low),
    .sdi_out(sdi),
    .sdo_wire_in(sdo_wire),
    .sdo_oe_in(sdo_oe)
  );

  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic peek(input logic [6:0] a);
    @(posedge mclk_in);
    core_addr_in <= a;
    repeat (2) @(posedge mclk_in);
    #1;
    check("register", mem[a], core_rdata);
  endtask : peek

  function automatic int stored(input int n, input logic wr);
    if (!wr || sleep_mode_in)
      return 0;
    return (n == 16) ? 1 : (n == 24) ? 2 : (n == 31 || n == 32) ? n - 29 : 0;
  endfunction : stored

  task automatic frame(input logic [31:0] ar, input logic wr, input int n,
    input logic [31:0] d);
    logic [6:0] a;
    logic [31:0] exp;
    logic [1:0] got;
    logic err;
    int nst;
    a = ar[6:0];
    @(posedge mclk_in);
    global_status_in <= 8'($urandom);
    repeat (6) @(posedge mclk_in);
    exp = {global_status_in, mem[a], mem[a + 7'h01], mem[a + 7'h02]};
    nst = stored(n, wr);
    err = !sleep_mode_in && n != 16 && n != 24 && n != 32;
    ssp_host_model_inst.xfer(n, {a, wr, d[23:0]});
    #1;
    check("idle enable", 1'b0, sdo_oe);
    check("frame enable", !sleep_mode_in,
      ssp_host_model_inst.oe_any);
    if (!sleep_mode_in)
      check("first bit", exp[31], ssp_host_model_inst.first_bit);
    if (!sleep_mode_in && n <= 32)
      check("stream", exp >> (32 - n),
        ssp_host_model_inst.rx);
    got = 2'h0;
    repeat (8)
    begin
      @(posedge mclk_in);
      #1;
      if (wr_pulse === 1'b1)
        got = wr_count;
    end
    check("bytes stored", nst, got);
    check("framing flag", err, flag);
    if (err)
    begin
      @(posedge mclk_in);
      err_clear_in <= 1'b1;
      @(posedge mclk_in);
      err_clear_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      #1;
      check("flag cleared", 1'b0, flag);
    end
    for (int k = 0; k < nst; k++)
      mem[a + k[6:0]] = d[23 - 8 * k -: 8];
    for (int k = 0; k < 3; k++)
      peek(a + k[6:0]);
    #2000;
  endtask : frame

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  always @(posedge mclk_in)
    if (wr_pulse === 1'b1 && chip_select_active_low === 1'b0)
    begin
      failures++;
      $display("unexpected store timing: expected idle, seen pulse");
    end

  initial
  begin
    #1_000_000;
    failures++;
    $display("unexpected watchdog: expected done, seen hang");
    report_and_stop();
  end

  initial
  begin
    rst_b_in = 1'b0;
    sleep_mode_in = 1'b0;
    err_clear_in = 1'b0;
    global_status_in = 8'h00;
    core_addr_in = 7'h00;
    failures = 0;
    n_checks = 0;
    foreach (mem[i])
      mem[i] = 8'h00;
    rnd = $urandom(37943);
    repeat (4) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    for (int i = 0; i < 4; i++)
      peek(7'($urandom));
    $display("test reset values done");
    // Top address wraps around inside a burst
    frame(32'h7f, 1'b1, 32, $urandom);
    for (int i = 0; i < 12; i++)
      frame($urandom, 1'b1, 8 + 8 * $urandom_range(3, 1), $urandom);
    $display("test writes done");
    for (int i = 0; i < 8; i++)
      frame($urandom, 1'b0, 8 + 8 * $urandom_range(3, 1), $urandom);
    $display("test reads done");
    foreach (bad[i])
      frame($urandom, 1'b1, bad[i], $urandom);
    $display("test bad counts done");
    @(posedge mclk_in);
    sleep_mode_in <= 1'b1;
    frame($urandom, 1'b1, 16, $urandom);
    @(posedge mclk_in);
    sleep_mode_in <= 1'b0;
    frame($urandom, 1'b0, 16, $urandom);
    $display("test sleep done");
    report_and_stop();
  end
endmodule : tb
